// ==== hdl/fpa_defs.svh ====
// register offsets, field positions, reset values and constants of the buffer port block
`ifndef FPA_DEFS_SVH
`define FPA_DEFS_SVH

`define FPA_ADDR_W          7
`define FPA_OFF_COUNT_HIGH  7'h72
`define FPA_OFF_COUNT_LOW   7'h73
`define FPA_OFF_FIFO_PORT   7'h74
`define FPA_OFF_IDENTITY    7'h75
`define FPA_OFF_X_HIGH      7'h77
`define FPA_OFF_X_LOW       7'h78
`define FPA_OFF_Y_HIGH      7'h7a
`define FPA_OFF_Y_LOW       7'h7b
`define FPA_OFF_Z_HIGH      7'h7d
`define FPA_OFF_Z_LOW       7'h7e

// buffer enable flag positions
`define FPA_EN_TEMP         7
`define FPA_EN_GYRO_X       6
`define FPA_EN_GYRO_Y       5
`define FPA_EN_GYRO_Z       4
`define FPA_EN_ACCEL        3

`define FPA_FIFO_DEPTH      4096
`define FPA_COUNT_W         13
`define FPA_SET_BYTES       14
`define FPA_LAST_BYTE       4'hd
`define FPA_ACCEL_BYTES     4'h6
`define FPA_TEMP_END        4'h8
`define FPA_GX_END          4'ha
`define FPA_GY_END          4'hc
`define FPA_EMPTY_VALUE     8'hff
`define FPA_SUBST_VALUE     8'hfe
`define FPA_OFFS_W          15
`define FPA_OFFS_RESET      15'h0000
`define FPA_FSR_MAX_SHIFT   3'h4
`define FPA_IDENTITY_VALUE  8'h5a

`endif

// ==== hdl/fpa_pkg.sv ====
// types shared by the buffer port block
package fpa_pkg;
   typedef enum logic {
      FPA_SEQ_IDLE,
      FPA_SEQ_RUN
   } fpa_seq_e;

   typedef logic [7:0]  fpa_byte_t;
   typedef logic [14:0] fpa_offs_t;
endpackage

// ==== hdl/fpa_regbank.sv ====
// buffer data port, identity register and accelerometer offset registers
`timescale 1ns/1ps
`include "fpa_defs.svh"

module fpa_regbank
   import fpa_pkg::*;
#(
   parameter int unsigned DEPTH    = `FPA_FIFO_DEPTH,
   // arbitrary identification value
   parameter fpa_byte_t   IDENTITY = `FPA_IDENTITY_VALUE
) (
   input  wire logic                      clock,
   input  wire logic                      rst_b,
   input  wire logic [`FPA_ADDR_W-1:0]    regAddr,
   input  wire logic                      regRdEn,
   input  wire logic                      regWrEn,
   input  wire logic [7:0]                regWrData,
   input  wire logic [7:0]                fifoEnable,
   input  wire logic                      stopOnFull,
   input  wire logic [1:0]                accelFsr,
   input  wire logic                      sampleStrobe,
   input  wire logic [47:0]               accelRaw,
   input  wire logic [63:0]               otherBytes,
   output logic      [7:0]                regRdData,
   output logic                           regRdValid,
   output logic                           overflowPulse,
   output logic      [47:0]               accelCorrected,
   output logic      [`FPA_COUNT_W-1:0]   fifoCount
);

   localparam int unsigned AW = $clog2(DEPTH);

   if (DEPTH < 2 || DEPTH > (1 << (`FPA_COUNT_W - 1))) begin : g_chk_range
      $error("fpa_regbank: DEPTH must lie from 2 to 4096");
   end
   if ((DEPTH & (DEPTH - 1)) != 0) begin : g_chk_pow2
      $error("fpa_regbank: DEPTH must be a power of two");
   end

   // byte of a sample set belongs to an enabled group
   function automatic logic byteEnabled(input logic [3:0] idx, input logic [7:0] en);
      logic r;
      r = 1'b0;
      if (idx < `FPA_ACCEL_BYTES) begin
         r = en[`FPA_EN_ACCEL];
      end else if (idx < `FPA_TEMP_END) begin
         r = en[`FPA_EN_TEMP];
      end else if (idx < `FPA_GX_END) begin
         r = en[`FPA_EN_GYRO_X];
      end else if (idx < `FPA_GY_END) begin
         r = en[`FPA_EN_GYRO_Y];
      end else begin
         r = en[`FPA_EN_GYRO_Z];
      end
      return r;
   endfunction

   // raw result minus offset scaled to the current range
   function automatic logic [15:0] applyOffset(input logic [15:0] raw, input fpa_offs_t offs,
                                               input logic [1:0] fsr);
      logic [15:0] scaled;
      logic [2:0]  sh;
      sh     = `FPA_FSR_MAX_SHIFT - {1'b0, fsr};
      scaled = {offs[14], offs} << sh;
      return raw - scaled;
   endfunction

   // sample bytes may never look like the empty marker
   function automatic fpa_byte_t cleanByte(input fpa_byte_t b);
      return (b == `FPA_EMPTY_VALUE) ? `FPA_SUBST_VALUE : b;
   endfunction

   // host strobe aimed at the buffer data port
   function automatic logic isPortAddr(input logic [`FPA_ADDR_W-1:0] a);
      return a == `FPA_OFF_FIFO_PORT;
   endfunction

   // low offset byte as read back, reserved bit clear
   function automatic fpa_byte_t offsLowByte(input fpa_offs_t offs);
      return {offs[6:0], 1'b0};
   endfunction

   // high count byte, unused top bits read zero
   function automatic fpa_byte_t countHighByte(input logic [`FPA_COUNT_W-1:0] c);
      return {3'h0, c[12:8]};
   endfunction

   // ring pointer step, wraps at the power-of-two depth
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return p + AW'(1);
   endfunction

   // offsets
   fpa_offs_t offsX_ff;
   fpa_offs_t offsY_ff;
   fpa_offs_t offsZ_ff;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         offsX_ff <= `FPA_OFFS_RESET;
      end else if (regWrEn) begin
         case (regAddr)
            `FPA_OFF_X_HIGH: offsX_ff[14:7] <= regWrData;
            `FPA_OFF_X_LOW:  offsX_ff[6:0]  <= regWrData[7:1];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         offsY_ff <= `FPA_OFFS_RESET;
      end else if (regWrEn) begin
         case (regAddr)
            `FPA_OFF_Y_HIGH: offsY_ff[14:7] <= regWrData;
            `FPA_OFF_Y_LOW:  offsY_ff[6:0]  <= regWrData[7:1];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         offsZ_ff <= `FPA_OFFS_RESET;
      end else if (regWrEn) begin
         case (regAddr)
            `FPA_OFF_Z_HIGH: offsZ_ff[14:7] <= regWrData;
            `FPA_OFF_Z_LOW:  offsZ_ff[6:0]  <= regWrData[7:1];
            default: ;
         endcase
      end
   end

   // corrected accel
   logic [47:0] nxt_accel;

   always_comb begin
      nxt_accel[47:32] = applyOffset(accelRaw[47:32], offsX_ff, accelFsr);
      nxt_accel[31:16] = applyOffset(accelRaw[31:16], offsY_ff, accelFsr);
      nxt_accel[15:0]  = applyOffset(accelRaw[15:0], offsZ_ff, accelFsr);
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         accelCorrected <= 48'h0;
      end else if (sampleStrobe) begin
         accelCorrected <= nxt_accel;
      end
   end

   // sample sequencer
   fpa_seq_e   seqState_ff;
   logic [3:0] byteIdx_ff;
   fpa_byte_t  snap_ff [`FPA_SET_BYTES];
   logic       hostPush;
   logic       seqPush;
   logic       seqRun;
   logic       setStart;
   logic       lastByte;
   fpa_byte_t  pushData;

   assign hostPush = regWrEn && isPortAddr(regAddr);
   assign seqRun   = seqState_ff == FPA_SEQ_RUN;
   // strobe during a running set is ignored
   assign setStart = (seqState_ff == FPA_SEQ_IDLE) && sampleStrobe;
   assign lastByte = byteIdx_ff == `FPA_LAST_BYTE;
   // host write takes the cycle; the sequencer holds its byte
   assign seqPush  = seqRun && !hostPush && byteEnabled(byteIdx_ff, fifoEnable);
   assign pushData = hostPush ? regWrData : snap_ff[byteIdx_ff];

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         seqState_ff <= FPA_SEQ_IDLE;
      end else begin
         case (seqState_ff)
            FPA_SEQ_IDLE: begin
               if (sampleStrobe) begin
                  seqState_ff <= FPA_SEQ_RUN;
               end
            end
            FPA_SEQ_RUN: begin
               if (!hostPush && lastByte) begin
                  seqState_ff <= FPA_SEQ_IDLE;
               end
            end
            default: seqState_ff <= FPA_SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         byteIdx_ff <= 4'h0;
      end else if (setStart) begin
         byteIdx_ff <= 4'h0;
      end else if (seqRun && !hostPush) begin
         byteIdx_ff <= byteIdx_ff + 4'h1;
      end
   end

   // whole set taken at the strobe, accel X high byte first
   always_ff @(posedge clock) begin
      if (setStart) begin
         for (int i = 0; i < 6; i++) begin
            snap_ff[i] <= cleanByte(nxt_accel[47 - 8 * i -: 8]);
         end
         for (int i = 0; i < 8; i++) begin
            snap_ff[6 + i] <= cleanByte(otherBytes[63 - 8 * i -: 8]);
         end
      end
   end

   // buffer
   fpa_byte_t               mem [DEPTH];
   logic [AW-1:0]           wrPtr_ff;
   logic [AW-1:0]           rdPtr_ff;
   logic [`FPA_COUNT_W-1:0] countLatch_ff;
   fpa_byte_t               portRdData;
   logic                    pushReq;
   logic                    popReq;
   logic                    isFull;
   logic                    doWrite;
   logic                    dropOld;
   logic                    countUp;
   logic                    countDown;
   logic                    overrun;
   logic                    countHighRd;

   assign pushReq     = hostPush || seqPush;
   assign popReq      = regRdEn && isPortAddr(regAddr) && (fifoCount != '0);
   // a pop in the same cycle makes room, so no overrun then
   assign isFull      = (fifoCount == `FPA_COUNT_W'(DEPTH)) && !popReq;
   assign doWrite     = pushReq && !(isFull && stopOnFull);
   assign dropOld     = pushReq && isFull && !stopOnFull;
   assign overrun     = pushReq && isFull;
   // push and pop together leave the count as it is
   assign countUp     = doWrite && !popReq && !dropOld;
   assign countDown   = popReq && !doWrite;
   assign portRdData  = popReq ? mem[rdPtr_ff] : `FPA_EMPTY_VALUE;
   assign countHighRd = regRdEn && (regAddr == `FPA_OFF_COUNT_HIGH);

   always_ff @(posedge clock) begin
      if (doWrite) begin
         mem[wrPtr_ff] <= pushData;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         wrPtr_ff <= '0;
      end else if (doWrite) begin
         wrPtr_ff <= bump(wrPtr_ff);
      end
   end

   // overwrite mode drops the oldest byte by stepping the read side
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rdPtr_ff <= '0;
      end else if (popReq || dropOld) begin
         rdPtr_ff <= bump(rdPtr_ff);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         fifoCount <= '0;
      end else if (countUp) begin
         fifoCount <= fifoCount + `FPA_COUNT_W'(1);
      end else if (countDown) begin
         fifoCount <= fifoCount - `FPA_COUNT_W'(1);
      end
   end

   // overrun flag itself lives in the status register outside
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         overflowPulse <= 1'b0;
      end else begin
         overflowPulse <= overrun;
      end
   end

   // low count byte reads the copy taken at the high byte read
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         countLatch_ff <= '0;
      end else if (countHighRd) begin
         countLatch_ff <= fifoCount;
      end
   end

   // read path
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         regRdData <= 8'h00;
      end else if (regRdEn) begin
         case (regAddr)
            `FPA_OFF_COUNT_HIGH: regRdData <= countHighByte(fifoCount);
            `FPA_OFF_COUNT_LOW:  regRdData <= countLatch_ff[7:0];
            `FPA_OFF_FIFO_PORT:  regRdData <= portRdData;
            `FPA_OFF_IDENTITY:   regRdData <= IDENTITY;
            `FPA_OFF_X_HIGH:     regRdData <= offsX_ff[14:7];
            `FPA_OFF_X_LOW:      regRdData <= offsLowByte(offsX_ff);
            `FPA_OFF_Y_HIGH:     regRdData <= offsY_ff[14:7];
            `FPA_OFF_Y_LOW:      regRdData <= offsLowByte(offsY_ff);
            `FPA_OFF_Z_HIGH:     regRdData <= offsZ_ff[14:7];
            `FPA_OFF_Z_LOW:      regRdData <= offsLowByte(offsZ_ff);
            default:             regRdData <= 8'h00;
         endcase
      end
   end

endmodule

// ==== verification/fpa_host.sv ====
// host model issuing register reads and writes
`timescale 1ns/1ps
module fpa_host (
   input  wire logic       clock,
   input  wire logic [7:0] regRdData,
   output logic      [6:0] regAddr,
   output logic            regRdEn,
   output logic            regWrEn,
   output logic      [7:0] regWrData
);
   initial begin
      regAddr   = 7'h00;
      regRdEn   = 1'h0;
      regWrEn   = 1'h0;
      regWrData = 8'h00;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'h1;
      @(posedge clock);
      regWrEn   <= 1'h0;
   endtask
   // data lands with the valid pulse at the taking edge, one cycle after the request is driven
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regRdEn <= 1'h1;
      @(posedge clock);
      regRdEn <= 1'h0;
      #1 d = regRdData;
   endtask
endmodule

// ==== verification/fpa_regbank_assertions.sv ====
// concurrent checks on the buffer port register block
`timescale 1ns/1ps
`include "fpa_defs.svh"
module fpa_regbank_chk
   import fpa_pkg::*;
#(
   parameter int unsigned DEPTH    = 16,
   parameter fpa_byte_t   IDENTITY = 8'h5a
) (
   input wire logic        clock,
   input wire logic        rst_b,
   input wire logic [6:0]  regAddr,
   input wire logic        regRdEn,
   input wire logic        regWrEn,
   input wire logic [7:0]  fifoEnable,
   input wire logic [7:0]  regRdData,
   input wire logic        regRdValid,
   input wire logic        overflowPulse,
   input wire logic [12:0] fifoCount
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic portRd;
   logic portWr;
   logic quiet;
   assign portRd = regRdEn && regAddr == `FPA_OFF_FIFO_PORT;
   assign portWr = regWrEn && regAddr == `FPA_OFF_FIFO_PORT;
   // no group enabled, so the sequencer cannot push
   assign quiet = fifoEnable == 8'h00;
   a_read_answer: assert property (regRdEn |=> regRdValid)
      else $error("read not answered");
   a_no_stray: assert property (!regRdEn |=> !regRdValid)
      else $error("stray read valid");
   a_identity_value: assert property (regRdEn && regAddr == `FPA_OFF_IDENTITY
      |=> regRdData == IDENTITY) else $error("wrong identity");
   a_empty_ff: assert property (portRd && fifoCount == 13'h0 && quiet
      |=> regRdData == 8'hff && fifoCount == 13'h0) else $error("empty read wrong");
   a_pop_count: assert property (portRd && fifoCount != 13'h0 && quiet
      |=> fifoCount == $past(fifoCount) - 13'h1) else $error("pop count wrong");
   a_push_count: assert property (portWr && fifoCount < DEPTH && quiet
      |=> fifoCount == $past(fifoCount) + 13'h1) else $error("push count wrong");
   a_full_overflow: assert property (portWr && fifoCount == DEPTH && quiet
      |=> overflowPulse && fifoCount == DEPTH) else $error("no overflow");
   a_overflow_cause: assert property (overflowPulse |-> $past(fifoCount) == DEPTH)
      else $error("overflow not full");
   a_count_bound: assert property (fifoCount <= DEPTH)
      else $error("count above depth");
   cover property (overflowPulse);
   cover property (portRd && fifoCount == 13'h0);
   cover property (regRdEn && regAddr == `FPA_OFF_COUNT_HIGH);
endmodule
bind fpa_regbank fpa_regbank_chk #(.DEPTH(DEPTH), .IDENTITY(IDENTITY)) i_fpa_regbank_chk (
   .clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regRdEn(regRdEn), .regWrEn(regWrEn),
   .fifoEnable(fifoEnable), .regRdData(regRdData), .regRdValid(regRdValid),
   .overflowPulse(overflowPulse), .fifoCount(fifoCount));

// ==== verification/tb.sv ====
// self-checking bench for the buffer port register block
`timescale 1ns/1ps
`include "fpa_defs.svh"
module tb;
   import fpa_pkg::*;
   localparam logic [6:0] PORT = `FPA_OFF_FIFO_PORT;
   logic        clock = 1'h0;
   logic        rst_b = 1'h0;
   logic        stopOnFull = 1'h0;
   logic        sampleStrobe = 1'h0;
   logic [1:0]  accelFsr = 2'h3;
   logic [7:0]  fifoEnable = 8'h00;
   logic [47:0] accelRaw = 48'h1234_5678_9abc;
   logic [63:0] otherBytes = 64'hff01_0203_0405_0607;
   logic [6:0]  regAddr;
   logic        regRdEn, regWrEn, regRdValid, overflowPulse;
   logic [7:0]  regWrData, regRdData, rb;
   logic [47:0] accelCorrected;
   logic [12:0] fifoCount;
   int          num_errors = 0;
   int          n_compared = 0;
   always #5 clock = ~clock;
   fpa_host i_fpa_host (.clock(clock), .regRdData(regRdData), .regAddr(regAddr),
      .regRdEn(regRdEn), .regWrEn(regWrEn), .regWrData(regWrData));
   fpa_regbank #(.DEPTH(16)) i_fpa_regbank (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
      .regRdEn(regRdEn), .regWrEn(regWrEn), .regWrData(regWrData), .fifoEnable(fifoEnable),
      .stopOnFull(stopOnFull), .accelFsr(accelFsr), .sampleStrobe(sampleStrobe),
      .accelRaw(accelRaw), .otherBytes(otherBytes), .regRdData(regRdData),
      .regRdValid(regRdValid), .overflowPulse(overflowPulse),
      .accelCorrected(accelCorrected), .fifoCount(fifoCount));
   task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      i_fpa_host.rd(a, rb);
      cmp(48'(rb), 48'(e));
   endtask
   // range 3 scales the offset by two; low bytes all hold 7f above the reserved bit
   function automatic logic [15:0] cor(input logic [15:0] raw, input logic [7:0] h);
      return raw - ({h[7], h, 7'h7f} << 1);
   endfunction
   task automatic t_regs();
      rdc(`FPA_OFF_IDENTITY, `FPA_IDENTITY_VALUE);
      i_fpa_host.wr(`FPA_OFF_IDENTITY, 8'h00);
      rdc(`FPA_OFF_IDENTITY, `FPA_IDENTITY_VALUE);
      rdc(7'h76, 8'h00);
      rdc(PORT, 8'hff);
      for (int i = 0; i < 3; i++) begin
         i_fpa_host.wr(7'h77 + 7'(3 * i), 8'h80 + 8'(i));
         i_fpa_host.wr(7'h78 + 7'(3 * i), 8'hff);
         rdc(7'h77 + 7'(3 * i), 8'h80 + 8'(i));
         rdc(7'h78 + 7'(3 * i), 8'hfe);
      end
      $display("register test done");
   endtask
   task automatic t_sample(input logic [7:0] en, input int n);
      logic [111:0] e;
      e = {cor(16'h1234, 8'h80), cor(16'h5678, 8'h81), cor(16'h9abc, 8'h82), 8'hfe,
           otherBytes[55:0]};
      @(posedge clock);
      fifoEnable   <= en;
      sampleStrobe <= 1'h1;
      @(posedge clock);
      sampleStrobe <= 1'h0;
      repeat (16) @(posedge clock);
      cmp(accelCorrected, e[111:64]);
      rdc(`FPA_OFF_COUNT_HIGH, 8'h00);
      rdc(`FPA_OFF_COUNT_LOW, 8'(n));
      for (int k = 0; k < n; k++) rdc(PORT, e[111 - 8 * k -: 8]);
      @(posedge clock);
      fifoEnable <= 8'h00;
      $display("sample test done");
   endtask
   task automatic t_ovf();
      for (int i = 0; i < 17; i++) i_fpa_host.wr(PORT, 8'(i));
      rdc(`FPA_OFF_COUNT_HIGH, 8'h00);
      rdc(`FPA_OFF_COUNT_LOW, 8'h10);
      rdc(PORT, 8'h01);
      @(posedge clock);
      stopOnFull <= 1'h1;
      i_fpa_host.wr(PORT, 8'h20);
      i_fpa_host.wr(PORT, 8'h55);
      #1 cmp(48'(overflowPulse), 48'h1);
      for (int k = 2; k < 18; k++) rdc(PORT, k < 17 ? 8'(k) : 8'h20);
      rdc(PORT, 8'hff);
      $display("overflow test done");
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clock);
      rst_b <= 1'h1;
      t_regs();
      t_sample(8'h08, 6);
      t_sample(8'hf8, 14);
      t_ovf();
      test_done();
   end
   initial begin
      repeat (3000) @(posedge clock);
      num_errors++;
      test_done();
   end
endmodule
